// file: design/mcu_port_dev.sv
// Device end of the MCU access port: parallel index/data port and serial slave
// Assumes the link interface; serial frame logic runs on the link clock sclk
//
// What this block does
// [RL1] Strap at reset picks serial or parallel
// [RL2] Interrupt output is active low
// [RL3] MCU may poll flag register instead; no flag register is kept here, irq_req reaches only the interrupt pin
// [RL4] Deselected: no operation, bus undriven
// [RL5] Both strobes high: no operation
// [RL6] Write with port select high loads index
// [RL7] Data write stores byte, then advances index
// [RL8] Data read drives byte, then advances index
// [RL9] Index-port read returns byte, index kept
// [RL10] Auto increment only at buffer addresses
// [RL11] Single direction bus: write strobe high reads
// [RL12] Serial modes 0 and 3, rise in, fall out
// [RL13] Serial bytes eight bits, MSB first
// [RL14] Serial output driven only after read command
// [RL15] MCU opens frame with select low, address
// [RL16] Second byte is read or write command
// [RL17] Serial write stores, then address plus one
// [RL18] Serial read streams bytes, address plus one
// [RL19] Select high ends frame
// [RL20] Reserved window not read or written
// [RL21] Endpoint zero buffers, eight or sixteen bytes
// [RL22] Endpoint one buffers at fixed windows
// [RL23] Host mode buffers at fixed windows
// [RL24] Eight bit index wraps; partial byte dropped
module mcu_port_dev (
  input  wire logic       clk,
  input  wire logic       reset_n,
  mcu_link_if.dev         link,
  input  wire logic       irq_req,
  output logic            serial_mode,
  output logic            wr_evt,
  output logic [7:0]      wr_evt_addr,
  output logic [7:0]      wr_evt_data
);

  typedef enum logic [2:0] {
    PH_ADDR = 3'b000,
    PH_CMD  = 3'b001,
    PH_WR   = 3'b011,
    PH_RD   = 3'b010,
    PH_SKIP = 3'b110
  } frame_phase_t;

  // Reserved window between registers and buffers
  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= mcu_port_pkg::RSV_LO) && (a <= mcu_port_pkg::RSV_HI); // [RL20]
  endfunction : is_reserved

  // Index advances only inside buffer space, wrapping at the top
  function automatic logic [7:0] next_index(input logic [7:0] a);
    next_index = (a >= mcu_port_pkg::BUF_BASE) ? 8'(a + 8'h01) : a; // [RL10] [RL24]
  endfunction : next_index

  // Flat store; endpoint and host buffer windows are fixed address ranges
  logic [7:0]   mem_q [256];
  logic [7:0]   idx_q;
  logic         serial_mode_q;
  logic         irq_n_q;
  logic [13:0]  sync1_q;
  logic [13:0]  sync2_q;
  logic         cs_n_s;
  logic         wr_n_s;
  logic         rd_n_s;
  logic         psel_s;
  logic [7:0]   d_s;
  logic         wr_tog_s;
  logic         rd_tog_s;
  logic         wr_act;
  logic         rd_act;
  logic         wr_act_q;
  logic         rd_act_q;
  logic         acc_psel_q;
  logic [7:0]   acc_d_q;
  logic         par_wr_done;
  logic         par_rd_done;
  logic [7:0]   pd_o_q;
  logic         pd_oe_q;
  logic         wr_seen_q;
  logic         rd_seen_q;
  logic         wr_hit;
  logic         rd_hit;
  logic [7:0]   rd_data_q;
  logic         rd_ack_q;
  logic         mem_we;
  logic [7:0]   mem_wa;
  logic [7:0]   mem_wd;
  logic         wr_evt_q;
  logic [7:0]   wr_evt_addr_q;
  logic [7:0]   wr_evt_data_q;
  // Link clock domain
  frame_phase_t phase_q;
  logic [2:0]   bit_q;
  logic [6:0]   sh_in_q;
  logic [7:0]   rx_byte;
  logic [7:0]   ser_addr_q;
  logic         wr_tog_q;
  logic         rd_tog_q;
  logic [7:0]   ser_wr_addr_q;
  logic [7:0]   ser_wr_data_q;
  logic [7:0]   ser_rd_addr_q;
  logic         ack1_q;
  logic         ack2_q;
  logic         so_q;
  logic         so_oe_q;
  logic [6:0]   sh_out_q;

  // Two-stage synchronisers for pins and link-domain toggles
  always_ff @(posedge clk) begin
    sync1_q <= {link.cs_n, link.wr_n, link.rd_n, link.port_select_line,
                link.parallel_data_bus, wr_tog_q, rd_tog_q};
    sync2_q <= sync1_q;
  end
  assign {cs_n_s, wr_n_s, rd_n_s, psel_s, d_s, wr_tog_s, rd_tog_s} = sync2_q;

  // Interface strap, caught while reset is held
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      serial_mode_q <= cs_n_s & ~wr_n_s & ~rd_n_s; // [RL1]
    end
  end

  // Interrupt pin follows the engine request, low when pending
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~irq_req; // [RL2]
    end
  end

  // Strobe decode; write strobe alone low is a write whatever the read strobe shows
  assign wr_act = ~serial_mode_q & ~cs_n_s & ~wr_n_s;          // [RL4] [RL5] [RL11]
  assign rd_act = ~serial_mode_q & ~cs_n_s & wr_n_s & ~rd_n_s; // [RL4] [RL5] [RL11]
  assign par_wr_done = wr_act_q & ~wr_act;
  assign par_rd_done = rd_act_q & ~rd_act;

  // Strobe history and address/data capture while a strobe is active
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      acc_psel_q <= 1'b0;
      acc_d_q    <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act || rd_act) begin
        acc_psel_q <= psel_s;
        acc_d_q    <= d_s;
      end
    end
  end

  // Index address register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idx_q <= mcu_port_pkg::IDX_RST;
    end else if (par_wr_done && acc_psel_q) begin
      idx_q <= acc_d_q; // [RL6]
    end else if ((par_wr_done || par_rd_done) && !acc_psel_q) begin
      idx_q <= next_index(idx_q); // [RL7] [RL8] [RL10]
    end
  end

  // Parallel read data; index-port reads leave the index alone
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pd_o_q  <= 8'h00;
      pd_oe_q <= 1'b0;
    end else begin
      pd_oe_q <= rd_act; // [RL4] [RL5]
      pd_o_q  <= is_reserved(idx_q) ? mcu_port_pkg::RSV_READ : mem_q[idx_q]; // [RL8] [RL9]
    end
  end

  // Serial requests arriving in the system domain
  assign wr_hit = serial_mode_q & (wr_tog_s ^ wr_seen_q);
  assign rd_hit = serial_mode_q & (rd_tog_s ^ rd_seen_q);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_seen_q <= 1'b0;
      rd_seen_q <= 1'b0;
      rd_ack_q  <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      wr_seen_q <= wr_tog_s;
      rd_seen_q <= rd_tog_s;
      if (rd_hit) begin
        rd_data_q <= is_reserved(ser_rd_addr_q) ? mcu_port_pkg::RSV_READ
                                                : mem_q[ser_rd_addr_q];
        rd_ack_q  <= rd_tog_s;
      end
    end
  end

  // Store write port shared by both interfaces; reserved window is not written
  always_comb begin
    mem_we = 1'b0;
    mem_wa = idx_q;
    mem_wd = acc_d_q;
    if (par_wr_done && !acc_psel_q) begin
      mem_we = ~is_reserved(idx_q); // [RL7] [RL20]
    end else if (wr_hit) begin
      mem_we = ~is_reserved(ser_wr_addr_q); // [RL17] [RL20]
      mem_wa = ser_wr_addr_q;
      mem_wd = ser_wr_data_q;
    end
  end

  // Buffer store; windows for both endpoints and host mode map straight through
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd; // [RL21] [RL22] [RL23]
    end
  end

  // Write notice to the engine
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_evt_q      <= 1'b0;
      wr_evt_addr_q <= 8'h00;
      wr_evt_data_q <= 8'h00;
    end else begin
      wr_evt_q <= mem_we;
      if (mem_we) begin
        wr_evt_addr_q <= mem_wa;
        wr_evt_data_q <= mem_wd;
      end
    end
  end

  // Serial frame state; select high clears it and drops any partial byte
  assign rx_byte = {sh_in_q, link.serial_in_line};

  always_ff @(posedge link.sclk or posedge link.serial_select_n) begin
    if (link.serial_select_n) begin
      phase_q    <= PH_ADDR; // [RL19] [RL24]
      bit_q      <= 3'h0;
      sh_in_q    <= 7'h00;
      ser_addr_q <= 8'h00;
    end else begin
      bit_q   <= 3'(bit_q + 3'h1); // [RL12] [RL13]
      sh_in_q <= rx_byte[6:0];
      if (bit_q == 3'h7) begin
        case (phase_q)
          PH_ADDR: begin
            ser_addr_q <= rx_byte; // [RL15]
            phase_q    <= PH_CMD;
          end
          PH_CMD: begin
            if (rx_byte == mcu_port_pkg::CMD_READ) begin
              phase_q <= PH_RD; // [RL16]
            end else if (rx_byte == mcu_port_pkg::CMD_WRITE) begin
              phase_q <= PH_WR; // [RL16]
            end else begin
              phase_q <= PH_SKIP;
            end
          end
          PH_WR:   ser_addr_q <= 8'(ser_addr_q + 8'h01); // [RL17]
          default: phase_q <= phase_q;
        endcase
      end else if (bit_q == 3'h0 && phase_q == PH_RD) begin
        ser_addr_q <= 8'(ser_addr_q + 8'h01); // [RL18]
      end
    end
  end

  // Requests to the system domain, toggles with held address and data
  always_ff @(posedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_tog_q      <= 1'b0;
      rd_tog_q      <= 1'b0;
      ser_wr_addr_q <= 8'h00;
      ser_wr_data_q <= 8'h00;
      ser_rd_addr_q <= 8'h00;
    end else if (!link.serial_select_n) begin
      if (bit_q == 3'h7 && phase_q == PH_ADDR) begin
        ser_rd_addr_q <= rx_byte; // Prefetch in case a read follows
        rd_tog_q      <= ~rd_tog_q;
      end else if (bit_q == 3'h7 && phase_q == PH_WR) begin
        ser_wr_addr_q <= ser_addr_q; // [RL17]
        ser_wr_data_q <= rx_byte;
        wr_tog_q      <= ~wr_tog_q;
      end else if (bit_q == 3'h0 && phase_q == PH_RD) begin
        ser_rd_addr_q <= 8'(ser_addr_q + 8'h01); // [RL18]
        rd_tog_q      <= ~rd_tog_q;
      end
    end
  end

  // Read acknowledge back into the link domain
  always_ff @(posedge link.sclk) begin
    ack1_q <= rd_ack_q;
    ack2_q <= ack1_q;
  end

  // Serial output on falling edges, driven only in a read frame
  always_ff @(negedge link.sclk or posedge link.serial_select_n) begin
    if (link.serial_select_n) begin
      so_q     <= 1'b0;
      so_oe_q  <= 1'b0; // [RL14] [RL19]
      sh_out_q <= 7'h00;
    end else if (phase_q == PH_RD && bit_q == 3'h0) begin
      so_oe_q <= 1'b1; // [RL14]
      {so_q, sh_out_q} <= (ack2_q == rd_tog_q) ? rd_data_q : 8'h00; // [RL18]
    end else begin
      so_q     <= sh_out_q[6]; // [RL12] [RL13]
      sh_out_q <= {sh_out_q[5:0], 1'b0};
    end
  end

  assign link.dev_d_o  = pd_o_q;
  assign link.dev_d_oe = pd_oe_q;
  assign link.so_o     = so_q;
  assign link.so_oe    = so_oe_q;
  assign link.irq_n    = irq_n_q;
  assign serial_mode   = serial_mode_q;
  assign wr_evt        = wr_evt_q;
  assign wr_evt_addr   = wr_evt_addr_q;
  assign wr_evt_data   = wr_evt_data_q;

endmodule : mcu_port_dev

// file: pkg/mcu_port_pkg.sv
// Shared constants for both ends of the MCU access port
// Assumes both ends run on one 20 MHz system clock
package mcu_port_pkg;
  // Address space
  localparam logic [7:0] IDX_RST   = 8'h00;
  localparam logic [7:0] BUF_BASE  = 8'h20;
  localparam logic [7:0] RSV_LO    = 8'h0F;
  localparam logic [7:0] RSV_HI    = 8'h1F;
  localparam logic [7:0] RSV_READ  = 8'h00;
  localparam logic [7:0] BUS_FLOAT = 8'hFF;
  // Serial direction commands
  localparam logic [7:0] CMD_READ  = 8'hC0;
  localparam logic [7:0] CMD_WRITE = 8'h80;
  // Serial frame: address byte, command byte, one data byte
  localparam logic [4:0] FRAME_LAST = 5'h17;
  // Host request codes
  localparam logic [1:0] OP_IDX_WR  = 2'h0;
  localparam logic [1:0] OP_DATA_WR = 2'h1;
  localparam logic [1:0] OP_DATA_RD = 2'h2;
  localparam logic [1:0] OP_IDX_RD  = 2'h3;
  // Timing, in ns and in system clock cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int PAR_SETUP_NS  = 100;
  localparam int PAR_STROBE_NS = 400;
  localparam int PAR_HOLD_NS   = 200;
  localparam int SCK_HALF_NS   = 400;
  localparam logic [3:0] PAR_SETUP_CYC  = 4'((PAR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PAR_STROBE_CYC = 4'((PAR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PAR_HOLD_CYC   = 4'((PAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SCK_HALF_CYC   = 4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : mcu_port_pkg

// file: pkg/mcu_link_if.sv
// Pins between the MCU and the access port, with bus resolution
// Assumes one driver per direction; an undriven data bus floats high
interface mcu_link_if;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       port_select_line;
  logic [7:0] host_d_o;
  logic       host_d_oe;
  logic [7:0] dev_d_o;
  logic       dev_d_oe;
  logic [7:0] parallel_data_bus;
  logic       sclk;
  logic       serial_select_n;
  logic       serial_in_line;
  logic       so_o;
  logic       so_oe;
  logic       serial_out_line;
  logic       irq_n;

  // Wire level from the enables
  assign parallel_data_bus = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hFF);
  assign serial_out_line   = so_oe ? so_o : 1'b1;

  modport dev (
    input  cs_n, wr_n, rd_n, port_select_line, parallel_data_bus,
    input  sclk, serial_select_n, serial_in_line,
    output dev_d_o, dev_d_oe, so_o, so_oe, irq_n
  );
  modport host (
    output cs_n, wr_n, rd_n, port_select_line, host_d_o, host_d_oe,
    output sclk, serial_select_n, serial_in_line,
    input  parallel_data_bus, serial_out_line, irq_n
  );
endinterface : mcu_link_if

// file: design/mcu_port_host.sv
// MCU end of the access port: parallel strobes or serial master
// Assumes the link interface; serial clock is divided from clk and driven out
module mcu_port_host (
  input  wire logic       clk,
  input  wire logic       reset_n,
  mcu_link_if.host        link,
  input  wire logic       use_serial,
  input  wire logic       req_valid,
  input  wire logic [1:0] req_op,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            irq_pending
);

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_SETUP  = 3'b001,
    H_STROBE = 3'b011,
    H_HOLD   = 3'b010,
    H_SEL    = 3'b100,
    H_SHIFT  = 3'b101,
    H_DESEL  = 3'b111
  } host_state_t;

  host_state_t state_q;
  logic [3:0]  cnt_q;
  logic        rd_q;
  logic [4:0]  bit_q;
  logic [23:0] tx_q;
  logic [7:0]  rx_q;
  logic [9:0]  sync1_q;
  logic [9:0]  sync2_q;
  logic        cs_n_q;
  logic        wr_n_q;
  logic        rd_n_q;
  logic        psel_q;
  logic [7:0]  d_o_q;
  logic        d_oe_q;
  logic        sclk_q;
  logic        sel_n_q;
  logic        si_q;
  logic        ready_q;
  logic        rsp_valid_q;
  logic [7:0]  rsp_data_q;
  logic        irq_q;

  // Synchronise returning pins
  always_ff @(posedge clk) begin
    sync1_q <= {link.irq_n, link.serial_out_line, link.parallel_data_bus};
    sync2_q <= sync1_q;
  end

  // Interrupt line seen as a pending flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ~sync2_q[9]; // [RL2]
    end
  end

  // Access sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q     <= H_IDLE;
      cnt_q       <= 4'h0;
      rd_q        <= 1'b0;
      bit_q       <= 5'h00;
      tx_q        <= 24'h000000;
      rx_q        <= 8'h00;
      cs_n_q      <= 1'b1; // [RL1]
      wr_n_q      <= ~use_serial;
      rd_n_q      <= ~use_serial;
      psel_q      <= 1'b0;
      d_o_q       <= 8'h00;
      d_oe_q      <= 1'b0;
      sclk_q      <= 1'b0;
      sel_n_q     <= 1'b1;
      si_q        <= 1'b0;
      ready_q     <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      if (cnt_q != 4'h0) begin
        cnt_q <= 4'(cnt_q - 4'h1);
      end
      case (state_q)
        H_IDLE: begin
          ready_q <= 1'b1;
          if (req_valid && ready_q) begin
            ready_q <= 1'b0;
            rd_q    <= req_op[1];
            if (use_serial) begin
              tx_q    <= {req_addr, req_op[1] ? mcu_port_pkg::CMD_READ // [RL16]
                                              : mcu_port_pkg::CMD_WRITE, req_data};
              sel_n_q <= 1'b0; // [RL15]
              si_q    <= req_addr[7]; // [RL13]
              bit_q   <= 5'h00;
              cnt_q   <= mcu_port_pkg::SCK_HALF_CYC;
              state_q <= H_SEL;
            end else begin
              cs_n_q  <= 1'b0;
              psel_q  <= (req_op == mcu_port_pkg::OP_IDX_WR) ||
                         (req_op == mcu_port_pkg::OP_IDX_RD);
              d_o_q   <= req_data;
              d_oe_q  <= ~req_op[1];
              cnt_q   <= mcu_port_pkg::PAR_SETUP_CYC;
              state_q <= H_SETUP;
            end
          end
        end
        H_SETUP: begin
          if (cnt_q == 4'h0) begin
            wr_n_q  <= rd_q;
            rd_n_q  <= ~rd_q;
            cnt_q   <= mcu_port_pkg::PAR_STROBE_CYC;
            state_q <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (cnt_q == 4'h0) begin
            rsp_data_q <= sync2_q[7:0];
            cs_n_q     <= 1'b1;
            wr_n_q     <= 1'b1;
            rd_n_q     <= 1'b1;
            d_oe_q     <= 1'b0;
            cnt_q      <= mcu_port_pkg::PAR_HOLD_CYC;
            state_q    <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (cnt_q == 4'h0) begin
            rsp_valid_q <= 1'b1;
            state_q     <= H_IDLE;
          end
        end
        H_SEL: begin
          if (cnt_q == 4'h0) begin
            cnt_q   <= mcu_port_pkg::SCK_HALF_CYC;
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (cnt_q == 4'h0 && !sclk_q) begin
            sclk_q <= 1'b1; // [RL12]
            cnt_q  <= mcu_port_pkg::SCK_HALF_CYC;
          end else if (cnt_q == 4'h0) begin
            sclk_q <= 1'b0;
            rx_q   <= {rx_q[6:0], sync2_q[8]};
            tx_q   <= {tx_q[22:0], 1'b0};
            si_q   <= tx_q[22];
            bit_q  <= 5'(bit_q + 5'h01);
            cnt_q  <= mcu_port_pkg::SCK_HALF_CYC;
            if (bit_q == mcu_port_pkg::FRAME_LAST) begin
              state_q <= H_DESEL;
            end
          end
        end
        H_DESEL: begin
          sel_n_q <= 1'b1; // [RL19]
          if (cnt_q == 4'h0) begin
            rsp_data_q  <= rx_q;
            rsp_valid_q <= 1'b1;
            state_q     <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign link.cs_n             = cs_n_q;
  assign link.wr_n             = wr_n_q;
  assign link.rd_n             = rd_n_q;
  assign link.port_select_line = psel_q;
  assign link.host_d_o         = d_o_q;
  assign link.host_d_oe        = d_oe_q;
  assign link.sclk             = sclk_q;
  assign link.serial_select_n  = sel_n_q;
  assign link.serial_in_line   = si_q;
  assign req_ready             = ready_q;
  assign rsp_valid             = rsp_valid_q;
  assign rsp_data              = rsp_data_q;
  assign irq_pending           = irq_q;

endmodule : mcu_port_host

// file: testbench/mcu_port_checker.sv
// Concurrent checks on the pins between the MCU end and the device end
// Assumes plain copies of the link interface signals; sclk made by the host end
module mcu_port_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic so_oe,
  input wire logic serial_out_line,
  input wire logic irq_n
);
  logic [4:0] bit_cnt_q;
  logic       rise_q;

  // Counts link clock rises within a frame, cleared by select high
  always_ff @(posedge sclk or posedge serial_select_n) begin
    if (serial_select_n) bit_cnt_q <= 5'h00;
    else if (bit_cnt_q != 5'h1F) bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  // Serial output level seen at each rise
  always_ff @(posedge sclk) begin
    rise_q <= serial_out_line;
  end

  property p_desel_float;
    @(posedge clk) disable iff (!reset_n) cs_n [*6] |-> !dev_d_oe;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("data bus driven while deselected");
  property p_idle_float;
    @(posedge clk) disable iff (!reset_n) (wr_n && rd_n) [*6] |-> !dev_d_oe;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("data bus driven with no strobe");
  property p_write_quiet;
    @(posedge clk) disable iff (!reset_n) (!cs_n && !wr_n) [*6] |-> !dev_d_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drives during a write");
  property p_read_drive;
    @(posedge clk) disable iff (!reset_n) (!cs_n && wr_n && !rd_n) [*6] |-> dev_d_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("device silent during a read");
  property p_no_fight;
    @(posedge clk) disable iff (!reset_n) !(dev_d_oe && host_d_oe);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data bus");
  property p_one_port;
    @(posedge clk) disable iff (!reset_n) !(!cs_n && !serial_select_n);
  endproperty
  a_one_port: assert property (p_one_port)
    else $error("parallel and serial selected together");
  property p_irq_idle;
    @(posedge clk) $rose(reset_n) |-> irq_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle)
    else $error("interrupt active straight after reset");
  property p_sel_float;
    @(posedge clk) disable iff (!reset_n) serial_select_n [*3] |-> !so_oe;
  endproperty
  a_sel_float: assert property (p_sel_float)
    else $error("serial output driven outside a frame");
  property p_cmd_first;
    @(posedge sclk) disable iff (!reset_n) (!serial_select_n && bit_cnt_q < 5'h10) |-> !so_oe;
  endproperty
  a_cmd_first: assert property (p_cmd_first)
    else $error("serial output driven before the command byte");
  property p_out_fall;
    @(negedge sclk) disable iff (!reset_n || serial_select_n) so_oe |-> serial_out_line == rise_q;
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("serial output moved while link clock high");

  c_read: cover property (@(posedge clk) $rose(dev_d_oe));
  c_frame: cover property (@(posedge clk) $fell(serial_select_n));
  c_stream: cover property (@(posedge clk) $rose(so_oe));
endmodule : mcu_port_checker

// file: testbench/tb.sv
// Top bench: MCU end and device end joined by the link interface
// Assumes a 20 MHz clk; the host end divides it down for the link clock
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] d;
    logic [7:0] e;
    logic       c;
  } row_t;
  logic        clk, reset_n, use_serial, irq_req, req_valid, req_ready, rsp_valid;
  logic        irq_pending, serial_mode, wr_evt;
  logic [1:0]  req_op;
  logic [7:0]  req_addr, req_data, rsp_data, wr_evt_addr, wr_evt_data;
  logic [23:0] si_cap_q, so_cap_q;
  int          n_fail = 0, num_checks = 0, cyc = 0, n_wr = 0;
  // Op, data, expected address or read byte, check enable
  row_t rows [19] = '{'{2'h0, 8'h05, 8'h00, 1'b0}, '{2'h1, 8'h3C, 8'h05, 1'b1},
    '{2'h1, 8'hC3, 8'h05, 1'b1}, '{2'h2, 8'h00, 8'hC3, 1'b1}, '{2'h3, 8'h00, 8'hC3, 1'b1},
    '{2'h0, 8'h40, 8'h00, 1'b0}, '{2'h1, 8'hA5, 8'h40, 1'b1}, '{2'h1, 8'h5A, 8'h41, 1'b1},
    '{2'h0, 8'h40, 8'h00, 1'b0}, '{2'h2, 8'h00, 8'hA5, 1'b1}, '{2'h2, 8'h00, 8'h5A, 1'b1},
    '{2'h0, 8'h10, 8'h00, 1'b0}, '{2'h1, 8'h77, 8'h00, 1'b0}, '{2'h2, 8'h00, 8'h00, 1'b1},
    '{2'h0, 8'hFF, 8'h00, 1'b0}, '{2'h1, 8'h11, 8'hFF, 1'b1}, '{2'h1, 8'h22, 8'h00, 1'b1},
    '{2'h0, 8'h00, 8'h00, 1'b0}, '{2'h2, 8'h00, 8'h22, 1'b1}};

  mcu_link_if mcu_link_if_i ();
  mcu_port_dev mcu_port_dev_i (.clk(clk), .reset_n(reset_n), .link(mcu_link_if_i),
    .irq_req(irq_req), .serial_mode(serial_mode), .wr_evt(wr_evt),
    .wr_evt_addr(wr_evt_addr), .wr_evt_data(wr_evt_data));
  mcu_port_host mcu_port_host_i (.clk(clk), .reset_n(reset_n), .link(mcu_link_if_i),
    .use_serial(use_serial), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .irq_pending(irq_pending));
  mcu_port_checker mcu_port_checker_i (.clk(clk), .reset_n(reset_n),
    .cs_n(mcu_link_if_i.cs_n), .wr_n(mcu_link_if_i.wr_n), .rd_n(mcu_link_if_i.rd_n),
    .host_d_oe(mcu_link_if_i.host_d_oe), .dev_d_oe(mcu_link_if_i.dev_d_oe),
    .sclk(mcu_link_if_i.sclk), .serial_select_n(mcu_link_if_i.serial_select_n),
    .so_oe(mcu_link_if_i.so_oe), .serial_out_line(mcu_link_if_i.serial_out_line),
    .irq_n(mcu_link_if_i.irq_n));

  // System clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Both serial lines shifted in on link clock rises within a frame
  always @(posedge mcu_link_if_i.sclk) begin
    if (!mcu_link_if_i.serial_select_n) begin
      si_cap_q <= {si_cap_q[22:0], mcu_link_if_i.serial_in_line};
      so_cap_q <= {so_cap_q[22:0], mcu_link_if_i.serial_out_line};
    end
  end

  // Counts store-write notices; one per stored byte
  always @(posedge clk) begin
    if (wr_evt === 1'b1) n_wr++;
  end

  // Cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Strap chosen while reset is held, then released
  task automatic do_reset(input logic ser);
    reset_n <= 1'b0;
    use_serial <= ser;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // One request held until taken, then wait for its response pulse
  task automatic do_req(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) n_fail++;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 600);
    if (n == 600) n_fail++;
  endtask : do_req

  // Main sequence
  initial begin
    reset_n = 1'b0;
    use_serial = 1'b0;
    irq_req = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 8'h00;
    req_data = 8'h00;
    do_reset(1'b0);
    chk1(serial_mode, 1'b0);
    foreach (rows[i]) begin
      do_req(rows[i].op, 8'h00, rows[i].d);
      repeat (4) @(posedge clk);
      if (rows[i].c) chk8((rows[i].op == 2'h1) ? wr_evt_addr : rsp_data, rows[i].e);
    end
    chk8(8'(n_wr), 8'h06);
    $display("test parallel rows done");
    irq_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk1(mcu_link_if_i.irq_n, 1'b0);
    chk1(irq_pending, 1'b1);
    irq_req <= 1'b0;
    repeat (8) @(posedge clk);
    chk1(irq_pending, 1'b0);
    $display("test interrupt done");
    do_reset(1'b1);
    chk1(serial_mode, 1'b1);
    do_req(2'h1, 8'h50, 8'h9E);
    repeat (8) @(posedge clk);
    chk8(wr_evt_addr, 8'h50);
    chk8(wr_evt_data, 8'h9E);
    chk8(si_cap_q[23:16], 8'h50);
    chk8(si_cap_q[15:8], mcu_port_pkg::CMD_WRITE);
    do_req(2'h2, 8'h50, 8'h00);
    chk8(rsp_data, 8'h9E);
    chk8(si_cap_q[15:8], mcu_port_pkg::CMD_READ);
    chk8(so_cap_q[7:0], 8'h9E);
    do_req(2'h2, 8'h41, 8'h00);
    chk8(rsp_data, 8'h5A);
    $display("test serial done");
    finish_test();
  end
endmodule : tb
